// >>> rtl/asr_pkg.sv
// package for the application register set: indices, field layouts, codes
// assumes a 64-bit pipeline that addresses registers by 7-bit index
package asr_pkg;
   localparam int          ASR_DATA_W    = 64;
   localparam int          ASR_IDX_W     = 7;
   localparam int          ASR_CFM_W     = 38;
   localparam int          ASR_EC_W      = 6;
   localparam int          ASR_PL_W      = 2;
   localparam int          ASR_UM_W      = 6;
   localparam int          ASR_PMD_N     = 4;
   localparam int          ASR_PMD_IDX_W = 2;
   localparam logic [6:0]  IDX_BSFP      = 7'h11;
   localparam logic [6:0]  IDX_BSSP      = 7'h12;
   localparam logic [6:0]  IDX_SNAT      = 7'h13;
   localparam logic [6:0]  IDX_CXV       = 7'h20;
   localparam logic [6:0]  IDX_USER_NAT_COLLECTION      = 7'h24;
   localparam logic [6:0]  IDX_ITC       = 7'h2C;
   localparam logic [6:0]  IDX_PFS       = 7'h40;
   localparam logic [6:0]  IDX_LC        = 7'h41;
   localparam logic [6:0]  IDX_EC        = 7'h42;
   localparam int          SNAT_IG_BIT   = 63;
   localparam int          PFS_CFM_LO    = 0;
   localparam int          PFS_CFM_HI    = 37;
   localparam int          PFS_EC_LO     = 52;
   localparam int          PFS_EC_HI     = 57;
   localparam int          PFS_PL_LO     = 62;
   localparam int          PFS_PL_HI     = 63;
   localparam int          UM_BE         = 1;
   localparam int          UM_UP         = 2;
   localparam int          UM_AC         = 3;
   localparam int          UM_MFL        = 4;
   localparam int          UM_MFH        = 5;
   localparam logic [5:0]  UM_WR_MASK    = 6'h3E;
   localparam logic [1:0]  PL_MOST       = 2'h0;
   localparam logic [63:0] ITC_STEP      = 64'h0000000000000001;
   localparam logic [63:0] ZERO64        = 64'h0000000000000000;
   typedef enum logic [1:0] {
      ASR_FLT_NONE,
      ASR_FLT_PRIV_REG,
      ASR_FLT_LEGACY_GP
   } asr_fault_type;
endpackage : asr_pkg

// >>> rtl/asr_um.sv
// user mask: be, up, ac, sticky fp-written flags
// assumes fp completion pulses come from the same clock
`timescale 1ns/10ps
module asr_um
   import asr_pkg::*;
(
   input  wire logic                i_mclk,
   input  wire logic                i_rst_n,
   input  wire logic                i_wr,
   input  wire logic [ASR_UM_W-1:0] i_wdata,
   input  wire logic                i_fp_lo_done,
   input  wire logic                i_fp_hi_done,
   output logic      [ASR_UM_W-1:0] o_um
);
   logic [ASR_UM_W-1:0] um;
   logic [ASR_UM_W-1:0] next_um;

   always_comb begin
      next_um = um;
      if (i_wr) begin
         next_um = i_wdata & UM_WR_MASK;
      end
      // a set in the write cycle wins, so no completion is lost
      if (i_fp_lo_done) begin
         next_um[UM_MFL] = 1'b1;
      end
      if (i_fp_hi_done) begin
         next_um[UM_MFH] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         um <= '0;
      end else begin
         um <= next_um;
      end
   end

   assign o_um = um;

   a_um_mfl_sticky: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      um[UM_MFL] && !i_wr |=> um[UM_MFL])
      else $error("low fp flag dropped without write");
   a_um_mfh_set: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_fp_hi_done |=> um[UM_MFH])
      else $error("high fp flag not set");
   a_um_rsv_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      um[0] == 1'b0)
      else $error("reserved mask bit set");
   c_um_write: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_wr && i_fp_lo_done);
endmodule : asr_um

// >>> rtl/asr_regs.sv
// application register set: stack pointers, collections, time counter,
// previous function state, loop and epilog counts, perf data, user mask
// assumes the pipeline issues one read and one write per cycle, same clock
`timescale 1ns/10ps
module asr_regs
   import asr_pkg::*;
(
   input  wire logic                     i_mclk,
   input  wire logic                     i_arst_n,
   // register access port from the pipeline
   input  wire logic                     i_rd,
   input  wire logic                     i_rd_legacy,
   input  wire logic [ASR_IDX_W-1:0]     i_rd_idx,
   input  wire logic                     i_wr,
   input  wire logic [ASR_IDX_W-1:0]     i_wr_idx,
   input  wire logic [ASR_DATA_W-1:0]    i_wdata,
   input  wire logic [ASR_PL_W-1:0]      i_cpl,
   // security and engine-side updates
   input  wire logic                     i_itc_secure,
   input  wire logic [ASR_PMD_N-1:0]     i_pmd_secure,
   input  wire logic                     i_bsfp_load,
   input  wire logic [ASR_DATA_W-1:0]    i_bsfp_val,
   input  wire logic                     i_bssp_load,
   input  wire logic [ASR_DATA_W-1:0]    i_bssp_val,
   input  wire logic                     i_snat_load,
   input  wire logic [ASR_DATA_W-1:0]    i_snat_val,
   input  wire logic                     i_user_nat_collection_load,
   input  wire logic [ASR_DATA_W-1:0]    i_user_nat_collection_val,
   // branch events
   input  wire logic                     i_call,
   input  wire logic                     i_ret,
   input  wire logic [ASR_CFM_W-1:0]     i_cfm,
   input  wire logic                     i_loop_br,
   // perf data
   input  wire logic                     i_pmd_rd,
   input  wire logic                     i_pmd_wr,
   input  wire logic [ASR_PMD_IDX_W-1:0] i_pmd_idx,
   input  wire logic                     i_pmd_inc,
   // user mask
   input  wire logic                     i_um_wr,
   input  wire logic [ASR_UM_W-1:0]      i_um_wdata,
   input  wire logic                     i_fp_lo_done,
   input  wire logic                     i_fp_hi_done,
   // answers
   output logic      [ASR_DATA_W-1:0]    o_rdata,
   output logic                          o_rvalid,
   output asr_fault_type                 o_fault,
   output logic      [ASR_DATA_W-1:0]    o_pmd_rdata,
   output logic      [ASR_DATA_W-1:0]    o_cxv_operand,
   output logic      [ASR_DATA_W-1:0]    o_bssp,
   output logic      [ASR_DATA_W-1:0]    o_snat,
   output logic      [ASR_DATA_W-1:0]    o_user_nat_collection,
   output logic      [ASR_CFM_W-1:0]     o_cfm_restore,
   output logic                          o_cfm_restore_vld,
   output logic      [ASR_PL_W-1:0]      o_cpl_next,
   output logic                          o_cpl_load,
   output logic      [ASR_EC_W-1:0]      o_ec,
   output logic      [ASR_DATA_W-1:0]    o_lc,
   output logic                          o_big_endian,
   output logic                          o_user_perf_en,
   output logic                          o_align_all,
   output logic      [ASR_UM_W-1:0]      o_um
);
   logic                  rst_meta;
   logic                  rst_n;
   logic [ASR_DATA_W-1:0] bsfp, bssp, snat, cxv, user_nat_collection, interval_time_counter, lc;
   logic [ASR_DATA_W-1:0] next_bsfp, next_bssp, next_snat, next_cxv;
   logic [ASR_DATA_W-1:0] next_user_nat_collection, next_itc, next_lc;
   logic [ASR_CFM_W-1:0]  pfs_cfm, next_pfs_cfm;
   logic [ASR_EC_W-1:0]   pfs_ec, next_pfs_ec, ec, next_ec;
   logic [ASR_PL_W-1:0]   pfs_pl, next_pfs_pl;
   logic [ASR_DATA_W-1:0] perf_monitor_data [ASR_PMD_N];
   logic [ASR_DATA_W-1:0] next_pmd [ASR_PMD_N];
   logic [ASR_DATA_W-1:0] rdata, next_rdata, pmd_rdata, next_pmd_rdata;
   logic                  rvalid, next_rvalid;
   asr_fault_type         fault, next_fault;
   logic [ASR_CFM_W-1:0]  cfm_rst, next_cfm_rst;
   logic                  cfm_vld, next_cfm_vld;
   logic [ASR_PL_W-1:0]   cpl_nx, next_cpl_nx;
   logic                  cpl_ld, next_cpl_ld;
   logic [ASR_UM_W-1:0]   um;
   logic                  top_pl;
   logic [ASR_DATA_W-1:0] pfs_word;

   // reset release through two flops
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   assign top_pl = (i_cpl == PL_MOST);

   always_comb begin
      pfs_word = ZERO64;
      pfs_word[PFS_CFM_HI:PFS_CFM_LO] = pfs_cfm;
      pfs_word[PFS_EC_HI:PFS_EC_LO]   = pfs_ec;
      pfs_word[PFS_PL_HI:PFS_PL_LO]   = pfs_pl;
   end

   // register state
   always_comb begin
      next_bsfp    = i_bsfp_load ? i_bsfp_val : bsfp;
      next_bssp    = bssp;
      next_snat    = snat;
      next_cxv     = cxv;
      next_user_nat_collection    = user_nat_collection;
      next_itc     = interval_time_counter + ITC_STEP;
      next_lc      = lc;
      next_ec      = ec;
      next_pfs_cfm = pfs_cfm;
      next_pfs_ec  = pfs_ec;
      next_pfs_pl  = pfs_pl;
      if (i_bssp_load) begin
         next_bssp = i_bssp_val;
      end
      if (i_snat_load) begin
         next_snat = i_snat_val;
      end
      if (i_user_nat_collection_load) begin
         next_user_nat_collection = i_user_nat_collection_val;
      end
      if (i_wr) begin
         unique case (i_wr_idx)
            IDX_BSSP: next_bssp = i_wdata;
            IDX_SNAT: next_snat = i_wdata;
            IDX_CXV:  next_cxv  = i_wdata;
            IDX_USER_NAT_COLLECTION: next_user_nat_collection = i_wdata;
            IDX_ITC: begin
               if (top_pl) begin
                  next_itc = i_wdata;
               end
            end
            IDX_PFS: begin
               next_pfs_cfm = i_wdata[PFS_CFM_HI:PFS_CFM_LO];
               next_pfs_ec  = i_wdata[PFS_EC_HI:PFS_EC_LO];
               next_pfs_pl  = i_wdata[PFS_PL_HI:PFS_PL_LO];
            end
            IDX_LC:   next_lc = i_wdata;
            IDX_EC:   next_ec = i_wdata[ASR_EC_W-1:0];
            default: begin
               // frame pointer and unknown indices ignore writes
               next_lc = next_lc;
            end
         endcase
      end
      next_snat[SNAT_IG_BIT] = 1'b0;
      if (i_loop_br) begin
         next_lc = lc - ITC_STEP;
      end
      if (i_call) begin
         next_pfs_cfm = i_cfm;
         next_pfs_ec  = ec;
         next_pfs_pl  = i_cpl;
      end else if (i_ret) begin
         next_ec = pfs_ec;
      end
   end

   // perf data, one entry per counter
   generate
      for (genvar g = 0; g < ASR_PMD_N; g++) begin : g_pmd
         always_comb begin
            next_pmd[g] = perf_monitor_data[g];
            if (i_pmd_inc && um[UM_UP]) begin
               next_pmd[g] = perf_monitor_data[g] + ITC_STEP;
            end
            if (i_pmd_wr && top_pl && (i_pmd_idx == ASR_PMD_IDX_W'(g))) begin
               next_pmd[g] = i_wdata;
            end
         end
         always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
               perf_monitor_data[g] <= ZERO64;
            end else begin
               perf_monitor_data[g] <= next_pmd[g];
            end
         end
      end
   endgenerate

   // read answers and branch outputs
   always_comb begin
      next_rdata     = ZERO64;
      next_rvalid    = 1'b0;
      next_fault     = ASR_FLT_NONE;
      next_pmd_rdata = ZERO64;
      next_cfm_rst   = cfm_rst;
      next_cfm_vld   = 1'b0;
      next_cpl_nx    = cpl_nx;
      next_cpl_ld    = 1'b0;
      if (i_rd_legacy) begin
         next_rvalid = 1'b1;
         if (i_itc_secure && !top_pl) begin
            next_fault = ASR_FLT_LEGACY_GP;
         end else begin
            next_rdata = interval_time_counter;
         end
      end else if (i_rd) begin
         next_rvalid = 1'b1;
         unique case (i_rd_idx)
            IDX_BSFP: next_rdata = bsfp;
            IDX_BSSP: next_rdata = bssp;
            IDX_SNAT: next_rdata = snat;
            IDX_CXV:  next_rdata = cxv;
            IDX_USER_NAT_COLLECTION: next_rdata = user_nat_collection;
            IDX_ITC: begin
               if (i_itc_secure && !top_pl) begin
                  next_fault = ASR_FLT_PRIV_REG;
               end else begin
                  next_rdata = interval_time_counter;
               end
            end
            IDX_PFS:  next_rdata = pfs_word;
            IDX_LC:   next_rdata = lc;
            IDX_EC:   next_rdata = {{(ASR_DATA_W-ASR_EC_W){1'b0}}, ec};
            default:  next_rdata = ZERO64;
         endcase
      end
      if (i_pmd_rd && !i_pmd_secure[i_pmd_idx]) begin
         next_pmd_rdata = perf_monitor_data[i_pmd_idx];
      end
      if (i_ret && !i_call) begin
         next_cfm_rst = pfs_cfm;
         next_cfm_vld = 1'b1;
         next_cpl_nx  = pfs_pl;
         // larger level number is less privilege, so only move down
         next_cpl_ld  = (pfs_pl >= i_cpl);
      end
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         bsfp    <= ZERO64;
         bssp    <= ZERO64;
         snat    <= ZERO64;
         cxv     <= ZERO64;
         user_nat_collection    <= ZERO64;
         interval_time_counter     <= ZERO64;
         lc      <= ZERO64;
         ec      <= '0;
         pfs_cfm <= '0;
         pfs_ec  <= '0;
         pfs_pl  <= '0;
         rdata   <= ZERO64;
         rvalid  <= 1'b0;
         fault   <= ASR_FLT_NONE;
         pmd_rdata <= ZERO64;
         cfm_rst <= '0;
         cfm_vld <= 1'b0;
         cpl_nx  <= '0;
         cpl_ld  <= 1'b0;
      end else begin
         bsfp    <= next_bsfp;
         bssp    <= next_bssp;
         snat    <= next_snat;
         cxv     <= next_cxv;
         user_nat_collection    <= next_user_nat_collection;
         interval_time_counter     <= next_itc;
         lc      <= next_lc;
         ec      <= next_ec;
         pfs_cfm <= next_pfs_cfm;
         pfs_ec  <= next_pfs_ec;
         pfs_pl  <= next_pfs_pl;
         rdata   <= next_rdata;
         rvalid  <= next_rvalid;
         fault   <= next_fault;
         pmd_rdata <= next_pmd_rdata;
         cfm_rst <= next_cfm_rst;
         cfm_vld <= next_cfm_vld;
         cpl_nx  <= next_cpl_nx;
         cpl_ld  <= next_cpl_ld;
      end
   end

   asr_um u_um (
      .i_mclk       (i_mclk),
      .i_rst_n      (rst_n),
      .i_wr         (i_um_wr),
      .i_wdata      (i_um_wdata),
      .i_fp_lo_done (i_fp_lo_done),
      .i_fp_hi_done (i_fp_hi_done),
      .o_um         (um)
   );

   assign o_rdata           = rdata;
   assign o_rvalid          = rvalid;
   assign o_fault           = fault;
   assign o_pmd_rdata       = pmd_rdata;
   assign o_cxv_operand     = cxv;
   assign o_bssp            = bssp;
   assign o_snat            = snat;
   assign o_user_nat_collection            = user_nat_collection;
   assign o_cfm_restore     = cfm_rst;
   assign o_cfm_restore_vld = cfm_vld;
   assign o_cpl_next        = cpl_nx;
   assign o_cpl_load        = cpl_ld;
   assign o_ec              = ec;
   assign o_lc              = lc;
   // engine and legacy accesses ignore this and stay little-endian
   assign o_big_endian      = um[UM_BE];
   assign o_user_perf_en    = um[UM_UP];
   assign o_align_all       = um[UM_AC];
   assign o_um              = um;

   // sampled reset keeps the release edge, where the counter is still held, out
   a_itc_count: assert property (@(posedge i_mclk) disable iff (!rst_n)
      rst_n && !(i_wr && i_wr_idx == IDX_ITC) |=> interval_time_counter == $past(interval_time_counter) + ITC_STEP)
      else $error("time counter did not step by one");
   a_itc_wr_priv: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_wr && i_wr_idx == IDX_ITC && !top_pl |=> interval_time_counter == $past(interval_time_counter) + ITC_STEP)
      else $error("unprivileged counter write took effect");
   a_itc_secure: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_rd && !i_rd_legacy && i_rd_idx == IDX_ITC && i_itc_secure && !top_pl
      |=> fault == ASR_FLT_PRIV_REG && rdata == ZERO64)
      else $error("secured counter read without fault");
   a_legacy_gp: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_rd_legacy && i_itc_secure && !top_pl |=> fault == ASR_FLT_LEGACY_GP)
      else $error("legacy read missed protection fault");
   a_snat_top: assert property (@(posedge i_mclk) disable iff (!rst_n)
      snat[SNAT_IG_BIT] == 1'b0)
      else $error("spill collection bit 63 set");
   a_call_save: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_call |=> pfs_ec == $past(ec) && pfs_pl == $past(i_cpl) && pfs_cfm == $past(i_cfm))
      else $error("call did not save state");
   a_ret_priv: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_ret && !i_call && pfs_pl < i_cpl |=> !cpl_ld)
      else $error("return raised privilege");
   a_loop_dec: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_loop_br |=> lc == $past(lc) - ITC_STEP)
      else $error("loop count not decremented");
   a_pmd_secure: assert property (@(posedge i_mclk) disable iff (!rst_n)
      i_pmd_rd && i_pmd_secure[i_pmd_idx] |=> pmd_rdata == ZERO64)
      else $error("secured perf counter read nonzero");
   c_call_ret: cover property (@(posedge i_mclk) disable iff (!rst_n)
      i_call ##[1:8] i_ret);
   c_itc_fault: cover property (@(posedge i_mclk) disable iff (!rst_n)
      fault == ASR_FLT_PRIV_REG);
   c_loop: cover property (@(posedge i_mclk) disable iff (!rst_n)
      i_loop_br [*3]);
endmodule : asr_regs

// >>> verification/asr_pipe_model.sv
// pipeline-side partner: frame marker, privilege level, branch and fp events
// assumes one clock shared with the register set; events are pulses held for n edges
`timescale 1ns/10ps
module asr_pipe_model
   import asr_pkg::*;
(
   input  wire logic                 i_mclk,
   input  wire logic [ASR_CFM_W-1:0] i_cfm_restore,
   input  wire logic                 i_cfm_restore_vld,
   input  wire logic [ASR_PL_W-1:0]  i_cpl_next,
   input  wire logic                 i_cpl_load,
   output logic                      o_call,
   output logic                      o_ret,
   output logic                      o_loop_br,
   output logic                      o_fp_lo_done,
   output logic                      o_fp_hi_done,
   output logic      [ASR_CFM_W-1:0] o_cfm,
   output logic      [ASR_PL_W-1:0]  o_cpl
);
   initial begin
      {o_call, o_ret, o_loop_br, o_fp_lo_done, o_fp_hi_done} = 5'h00;
      o_cfm = 38'h0;
      o_cpl = 2'h0;
   end
   // the pipeline adopts whatever a return hands back, so a wrong level shows later
   always @(posedge i_mclk) begin
      if (i_cfm_restore_vld) o_cfm <= i_cfm_restore;
      if (i_cpl_load) o_cpl <= i_cpl_next;
   end
   task automatic pulse(input logic [4:0] ev, input int n);
      {o_call, o_ret, o_loop_br, o_fp_lo_done, o_fp_hi_done} <= ev;
      repeat (n) @(posedge i_mclk);
      {o_call, o_ret, o_loop_br, o_fp_lo_done, o_fp_hi_done} <= 5'h00;
   endtask : pulse
   task automatic set_state(input logic [ASR_CFM_W-1:0] current_frame_marker, input logic [ASR_PL_W-1:0] pl);
      o_cfm <= current_frame_marker;
      o_cpl <= pl;
   endtask : set_state
endmodule : asr_pipe_model

// >>> verification/application_register_set_tb.sv
// self-checking bench for the application register set
// assumes tasks are entered at a rising edge and return at one
`timescale 1ns/10ps
module application_register_set_tb
   import asr_pkg::*;
;
   logic          mclk = 1'h0, arst_n = 1'h0, rd = 1'h0, rdl = 1'h0, wr = 1'h0, sec = 1'h0;
   logic          bsfp_ld = 1'h0, bssp_ld = 1'h0, snat_ld = 1'h0, user_nat_collection_ld = 1'h0;
   logic          pmd_rd = 1'h0, pmd_wr = 1'h0, pmd_inc = 1'h0, um_wr = 1'h0;
   logic [6:0]    rd_idx = 7'h00, wr_idx = 7'h00;
   logic [63:0]   wdata = 64'h0, ld_val = 64'h0;
   logic [3:0]    pmd_sec = 4'h0;
   logic [1:0]    pmd_idx = 2'h0;
   logic [5:0]    um_wdata = 6'h00;
   logic          call, ret, loop_br, fp_lo, fp_hi, rvalid, cfm_vld, cpl_ld, be, upe, ac;
   logic [37:0]   current_frame_marker, cfm_rs;
   logic [1:0]    cpl, cpl_nx;
   logic [63:0]   rdata, pmd_rdata, cxv, bssp, snat, user_nat_collection, lc;
   logic [5:0]    ec, um;
   asr_fault_type flt;
   int            n_mismatch = 0, samples_checked = 0;

   initial forever #2.5 mclk = ~mclk;

   asr_regs dut (
      .i_mclk(mclk), .i_arst_n(arst_n), .i_rd(rd), .i_rd_legacy(rdl), .i_rd_idx(rd_idx),
      .i_wr(wr), .i_wr_idx(wr_idx), .i_wdata(wdata), .i_cpl(cpl), .i_itc_secure(sec),
      .i_pmd_secure(pmd_sec), .i_bsfp_load(bsfp_ld), .i_bsfp_val(ld_val),
      .i_bssp_load(bssp_ld), .i_bssp_val(ld_val), .i_snat_load(snat_ld), .i_snat_val(ld_val),
      .i_user_nat_collection_load(user_nat_collection_ld), .i_user_nat_collection_val(ld_val), .i_call(call), .i_ret(ret), .i_cfm(current_frame_marker),
      .i_loop_br(loop_br), .i_pmd_rd(pmd_rd), .i_pmd_wr(pmd_wr), .i_pmd_idx(pmd_idx),
      .i_pmd_inc(pmd_inc), .i_um_wr(um_wr), .i_um_wdata(um_wdata), .i_fp_lo_done(fp_lo),
      .i_fp_hi_done(fp_hi), .o_rdata(rdata), .o_rvalid(rvalid), .o_fault(flt),
      .o_pmd_rdata(pmd_rdata), .o_cxv_operand(cxv), .o_bssp(bssp), .o_snat(snat),
      .o_user_nat_collection(user_nat_collection), .o_cfm_restore(cfm_rs), .o_cfm_restore_vld(cfm_vld),
      .o_cpl_next(cpl_nx), .o_cpl_load(cpl_ld), .o_ec(ec), .o_lc(lc), .o_big_endian(be),
      .o_user_perf_en(upe), .o_align_all(ac), .o_um(um));

   asr_pipe_model pipe (
      .i_mclk(mclk), .i_cfm_restore(cfm_rs), .i_cfm_restore_vld(cfm_vld),
      .i_cpl_next(cpl_nx), .i_cpl_load(cpl_ld), .o_call(call), .o_ret(ret),
      .o_loop_br(loop_br), .o_fp_lo_done(fp_lo), .o_fp_hi_done(fp_hi), .o_cfm(current_frame_marker),
      .o_cpl(cpl));

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_flt(input asr_fault_type exp, input asr_fault_type got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED fault expected %0d seen %0d", exp, got);
      end
   endtask : chk_flt
   task automatic wr_reg(input logic [6:0] idx, input logic [63:0] d);
      wr <= 1'h1;
      wr_idx <= idx;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'h0;
      @(posedge mclk);
   endtask : wr_reg
   // answer stands one cycle, so it is taken mid-cycle after the read edge
   task automatic rd_reg(input logic [6:0] idx, input logic leg, output logic [63:0] d,
                         output asr_fault_type f);
      rd <= ~leg;
      rdl <= leg;
      rd_idx <= idx;
      @(posedge mclk);
      rd <= 1'h0;
      rdl <= 1'h0;
      @(negedge mclk);
      chk("rvalid", 64'h1, {63'h0, rvalid});
      d = rdata;
      f = flt;
      @(posedge mclk);
   endtask : rd_reg
   task automatic rd_chk(input logic [6:0] idx, input logic [63:0] exp);
      logic [63:0]   d;
      asr_fault_type f;
      rd_reg(idx, 1'h0, d, f);
      chk("rdata", exp, d);
      chk_flt(ASR_FLT_NONE, f);
   endtask : rd_chk
   task automatic pmd_chk(input logic [1:0] idx, input logic [63:0] exp);
      pmd_rd <= 1'h1;
      pmd_idx <= idx;
      @(posedge mclk);
      pmd_rd <= 1'h0;
      @(negedge mclk);
      chk("pmd rdata", exp, pmd_rdata);
      @(posedge mclk);
   endtask : pmd_chk
   task automatic pmd_write(input logic [1:0] idx, input logic [63:0] d);
      pmd_wr <= 1'h1;
      pmd_idx <= idx;
      wdata <= d;
      @(posedge mclk);
      pmd_wr <= 1'h0;
   endtask : pmd_write
   task automatic um_write(input logic [5:0] v);
      um_wr <= 1'h1;
      um_wdata <= v;
      @(posedge mclk);
      um_wr <= 1'h0;
   endtask : um_write

   task automatic t_regs();
      ld_val <= 64'h0123_4567_89AB_CDE8;
      {bsfp_ld, bssp_ld, user_nat_collection_ld} <= 3'h7;
      @(posedge mclk);
      {bsfp_ld, bssp_ld, user_nat_collection_ld} <= 3'h0;
      wr_reg(IDX_BSFP, 64'h0);
      rd_chk(IDX_BSFP, 64'h0123_4567_89AB_CDE8);
      chk("user_nat_collection", 64'h0123_4567_89AB_CDE8, user_nat_collection);
      wr_reg(IDX_BSSP, 64'hFEDC_BA98_7654_3210);
      wr_reg(IDX_CXV, 64'hA5A5_5A5A_0F0F_F0F0);
      wr_reg(IDX_USER_NAT_COLLECTION, 64'h8000_0000_0000_0001);
      rd_chk(IDX_BSSP, 64'hFEDC_BA98_7654_3210);
      chk("bssp", 64'hFEDC_BA98_7654_3210, bssp);
      chk("cxv operand", 64'hA5A5_5A5A_0F0F_F0F0, cxv);
      rd_chk(IDX_USER_NAT_COLLECTION, 64'h8000_0000_0000_0001);
      rd_chk(7'h15, 64'h0);
      wr_reg(IDX_SNAT, 64'hFFFF_FFFF_FFFF_FFFF);
      rd_chk(IDX_SNAT, 64'h7FFF_FFFF_FFFF_FFFF);
      ld_val <= 64'h8000_0000_0000_00C3;
      snat_ld <= 1'h1;
      @(posedge mclk);
      snat_ld <= 1'h0;
      rd_chk(IDX_SNAT, 64'h0000_0000_0000_00C3);
      chk("snat", 64'h0000_0000_0000_00C3, snat);
   endtask : t_regs

   // near-wrap value so the reads also show the roll-over
   task automatic t_itc();
      logic [63:0]   d;
      asr_fault_type f;
      wr_reg(IDX_ITC, 64'hFFFF_FFFF_FFFF_FFFC);
      pipe.set_state(current_frame_marker, 2'h3);
      wr_reg(IDX_ITC, 64'h0);
      rd_reg(IDX_ITC, 1'h0, d, f);
      chk("itc", 64'hFFFF_FFFF_FFFF_FFFF, d);
      rd_reg(IDX_ITC, 1'h1, d, f);
      chk("legacy itc", 64'h1, d);
      chk_flt(ASR_FLT_NONE, f);
      sec <= 1'h1;
      rd_reg(IDX_ITC, 1'h0, d, f);
      chk("secured itc", 64'h0, d);
      chk_flt(ASR_FLT_PRIV_REG, f);
      rd_reg(IDX_ITC, 1'h1, d, f);
      chk_flt(ASR_FLT_LEGACY_GP, f);
      pipe.set_state(current_frame_marker, 2'h0);
      rd_reg(IDX_ITC, 1'h0, d, f);
      chk_flt(ASR_FLT_NONE, f);
      sec <= 1'h0;
   endtask : t_itc

   task automatic t_pfs();
      pipe.set_state(38'h15_5555_AAAA, 2'h2);
      wr_reg(IDX_EC, 64'hFFFF_FFFF_FFFF_FFED);
      rd_chk(IDX_EC, 64'h2D);
      pipe.pulse(5'h10, 1);
      rd_chk(IDX_PFS, {2'h2, 4'h0, 6'h2D, 14'h0, 38'h15_5555_AAAA});
      wr_reg(IDX_PFS, 64'hFFFF_FFFF_FFFF_FFFF);
      rd_chk(IDX_PFS, 64'hC3F0_003F_FFFF_FFFF);
      pipe.pulse(5'h08, 1);
      @(negedge mclk);
      chk("cfm restore", 64'h3F_FFFF_FFFF, {26'h0, cfm_rs});
      chk("restore valid", 64'h1, {63'h0, cfm_vld});
      chk("ec", 64'h3F, {58'h0, ec});
      chk("cpl load", 64'h1, {63'h0, cpl_ld});
      chk("cpl next", 64'h3, {62'h0, cpl_nx});
      @(posedge mclk);
      wr_reg(IDX_PFS, 64'h0000_0000_0000_0001);
      pipe.pulse(5'h08, 1);
      @(negedge mclk);
      chk("cpl load", 64'h0, {63'h0, cpl_ld});
      chk("cfm restore", 64'h1, {26'h0, cfm_rs});
      @(posedge mclk);
      wr_reg(IDX_LC, 64'h0000_0000_0000_0001);
      pipe.pulse(5'h04, 2);
      @(negedge mclk);
      chk("lc", 64'hFFFF_FFFF_FFFF_FFFF, lc);
      chk("cpl", 64'h3, {62'h0, cpl});
      @(posedge mclk);
   endtask : t_pfs

   task automatic t_pmd();
      pipe.set_state(current_frame_marker, 2'h0);
      pmd_write(2'h1, 64'h1234);
      pmd_chk(2'h1, 64'h1234);
      pipe.set_state(current_frame_marker, 2'h3);
      pmd_write(2'h1, 64'h0099);
      pmd_chk(2'h1, 64'h1234);
      pmd_inc <= 1'h1;
      @(posedge mclk);
      pmd_inc <= 1'h0;
      pmd_chk(2'h1, 64'h1234);
      um_write(6'h04);
      pmd_inc <= 1'h1;
      @(posedge mclk);
      pmd_inc <= 1'h0;
      pmd_chk(2'h1, 64'h1235);
      chk("perf enable", 64'h1, {63'h0, upe});
      pmd_sec <= 4'h2;
      pmd_chk(2'h1, 64'h0);
      pipe.set_state(current_frame_marker, 2'h0);
      pmd_chk(2'h1, 64'h0);
      pmd_sec <= 4'h0;
   endtask : t_pmd

   task automatic t_um();
      um_write(6'h3F);
      @(negedge mclk);
      chk("um", 64'h3E, {58'h0, um});
      chk("be ac", 64'h3, {62'h0, be, ac});
      @(posedge mclk);
      um_write(6'h00);
      pipe.pulse(5'h02, 1);
      @(posedge mclk);
      pipe.pulse(5'h01, 1);
      @(negedge mclk);
      chk("um", 64'h30, {58'h0, um});
      @(posedge mclk);
      um_write(6'h02);
      @(negedge mclk);
      chk("um", 64'h02, {58'h0, um});
      chk("be ac", 64'h2, {62'h0, be, ac});
      @(posedge mclk);
      // completion in the clearing write's cycle must survive
      fork
         um_write(6'h00);
         pipe.pulse(5'h02, 1);
      join
      @(negedge mclk);
      chk("um", 64'h10, {58'h0, um});
      @(posedge mclk);
   endtask : t_um

   task automatic results();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results

   // whole sequence is about 110 cycles; this is ample slack
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      results();
   end

   initial begin
      repeat (20) @(posedge mclk);
      arst_n <= 1'h1;
      repeat (3) @(posedge mclk);
      t_regs();
      t_itc();
      t_pfs();
      t_pmd();
      t_um();
      results();
   end
endmodule : application_register_set_tb
